//--- logic/fclg_top.sv
// commutation and rotor-lock protection for a two-coil fan driver
`timescale 1ns/100ps
`include "fclg_map.svh"

module fclg_top #(
  parameter int unsigned RETRY_ON_CYC = `FCLG_RETRY_ON_CYC,
  parameter int unsigned SHUTDOWN_CYC = `FCLG_SHUTDOWN_CYC
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic hall_pol,
  output logic coil_phase_one,
  output logic coil_phase_two,
  output logic rotor_locked,
  output logic rotor_state_oe,
  output logic lock_timer_state
);

  localparam logic [`FCLG_TMR_W-1:0] ON_LIM = `FCLG_TMR_W'(RETRY_ON_CYC);
  localparam logic [`FCLG_TMR_W-1:0] OFF_LIM = `FCLG_TMR_W'(SHUTDOWN_CYC);

  fclg_pkg::fclg_state_t state_q;
  fclg_pkg::fclg_state_t state_d;
  logic hall_q;
  logic hall_edge;
  logic coil_one_q;
  logic coil_two_q;
  logic locked_q;
  logic tmr_clear;
  logic tmr_done;
  logic [`FCLG_TMR_W-1:0] tmr_limit;
  logic [`FCLG_TMR_W-1:0] tmr_count;
  logic in_shut;

  // drive is permitted everywhere but in the shutdown interval
  function automatic logic fclg_drive_on(input fclg_pkg::fclg_state_t st);
    fclg_drive_on = (st != fclg_pkg::fclg_st_shut);
  endfunction : fclg_drive_on

  // polarity history; any reversal is taken as rotor movement
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      hall_q <= `FCLG_HALL_RST;
    end else begin
      hall_q <= hall_pol;
    end
  end

  assign hall_edge = hall_pol ^ hall_q;

  // next state: the timer closes each interval, a polarity edge
  // proves rotation
  always_comb begin
    state_d = state_q;
    case (state_q)
      fclg_pkg::fclg_st_run: begin
        if (tmr_done && !hall_edge) begin
          state_d = fclg_pkg::fclg_st_shut;
        end
      end
      fclg_pkg::fclg_st_shut: begin
        if (tmr_done) begin
          state_d = fclg_pkg::fclg_st_retry;
        end
      end
      fclg_pkg::fclg_st_retry: begin
        if (hall_edge) begin
          state_d = fclg_pkg::fclg_st_run;
        end else if (tmr_done) begin
          state_d = fclg_pkg::fclg_st_shut;
        end
      end
      default: begin
        state_d = fclg_pkg::fclg_st_shut;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= fclg_pkg::fclg_st_run;
    end else begin
      state_q <= state_d;
    end
  end

  // polarity edges are ignored while shut so that a coasting rotor
  // cannot restart the off-time count and stretch it
  assign tmr_clear = (state_d != state_q) ||
                     (hall_edge && fclg_drive_on(state_q));
  // limit follows the present state: the next state depends on done
  assign tmr_limit = (state_q == fclg_pkg::fclg_st_shut) ? OFF_LIM
                                                         : ON_LIM;

  fclg_timer u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clear(tmr_clear),
    .limit(tmr_limit),
    .count(tmr_count),
    .done(tmr_done)
  );

  // coils registered from the next state so that the first shut
  // cycle already has both off
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      coil_one_q <= `FCLG_COIL_ONE_RST;
      coil_two_q <= `FCLG_COIL_TWO_RST;
    end else begin
      coil_one_q <= fclg_drive_on(state_d) && hall_pol;
      coil_two_q <= fclg_drive_on(state_d) && !hall_pol;
    end
  end

  // latched indication: held through retries until rotation returns
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      locked_q <= `FCLG_LOCKED_RST;
    end else begin
      locked_q <= (state_d != fclg_pkg::fclg_st_run);
    end
  end

  assign coil_phase_one = coil_one_q;
  assign coil_phase_two = coil_two_q;
  assign rotor_locked = locked_q;
  // open-drain: pulled low only while rotating, released when locked
  assign rotor_state_oe = !locked_q;
  assign lock_timer_state = locked_q;
  assign in_shut = (state_q == fclg_pkg::fclg_st_shut);

  AST_EXCLUSIVE: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !in_shut |-> (coil_phase_one ^ coil_phase_two))
    else $error("coil outputs not exclusive while driving");

  AST_FOLLOW: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    !in_shut |-> (coil_phase_one == hall_q))
    else $error("coil selection does not follow polarity");

  AST_SWAP: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (!in_shut && hall_edge && state_d != fclg_pkg::fclg_st_shut)
    |=> (coil_phase_one != $past(coil_phase_one)))
    else $error("coils did not swap on polarity reversal");

  AST_OFF: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    in_shut |-> (!coil_phase_one && !coil_phase_two))
    else $error("coil energised during shutdown");

  AST_LOCK_SET: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $rose(rotor_locked) |-> in_shut)
    else $error("lock indication raised outside shutdown");

  AST_RESTART: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (in_shut && tmr_done) |=> (state_q == fclg_pkg::fclg_st_retry) ##0
    (coil_phase_one ^ coil_phase_two))
    else $error("no restart after shutdown interval");

  AST_REPEAT: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_q == fclg_pkg::fclg_st_retry && tmr_done && !hall_edge)
    |=> in_shut)
    else $error("failed retry did not shut down again");

  AST_ON_TIME: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    ($rose(in_shut) && $past(state_q) == fclg_pkg::fclg_st_retry)
    |-> ($past(tmr_count) == ON_LIM - `FCLG_TMR_W'(1)))
    else $error("retry drive interval has wrong length");

  AST_RETRY_WAIT: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_q == fclg_pkg::fclg_st_retry && !hall_edge && !tmr_done)
    |=> (state_q == fclg_pkg::fclg_st_retry))
    else $error("retry drive interval cut short");

  AST_OFF_TIME: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    $fell(in_shut) |-> ($past(tmr_count) == OFF_LIM - `FCLG_TMR_W'(1)))
    else $error("shutdown interval has wrong length");

  AST_SHUT_HOLD: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (in_shut && !tmr_done) |=> in_shut)
    else $error("shutdown left before its interval ended");

  AST_CNT_BOUND: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    tmr_count < tmr_limit)
    else $error("interval timer ran past its limit");

  AST_RD_LOCKED: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_q != fclg_pkg::fclg_st_run) |-> (rotor_locked && !rotor_state_oe))
    else $error("rotor-state output not released while locked");

  AST_RD_RUN: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_q == fclg_pkg::fclg_st_run) |-> (!rotor_locked && rotor_state_oe))
    else $error("rotor-state output not low while rotating");

  AST_LATCHED: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (rotor_locked && !(state_q == fclg_pkg::fclg_st_retry && hall_edge))
    |=> rotor_locked)
    else $error("lock indication dropped without rotation");

  AST_RECOVER: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_q == fclg_pkg::fclg_st_retry && hall_edge)
    |=> (state_q == fclg_pkg::fclg_st_run) ##0 !rotor_locked)
    else $error("no return to normal run after rotation resumed");

  AST_STALL: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_q == fclg_pkg::fclg_st_run && tmr_done && !hall_edge)
    |=> in_shut ##0 rotor_locked)
    else $error("stalled rotor not detected");

  AST_RUN_HOLD: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_q == fclg_pkg::fclg_st_run && (!tmr_done || hall_edge))
    |=> (state_q == fclg_pkg::fclg_st_run))
    else $error("lock declared while rotor still turning");

  AST_KEEP_RUN: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (state_q == fclg_pkg::fclg_st_run && hall_edge)
    |=> (state_q == fclg_pkg::fclg_st_run) ##0 (tmr_count == '0))
    else $error("polarity edge did not restart stall timer");

endmodule : fclg_top

//--- logic/fclg_map.svh
// constants for the fan commutation and rotor-lock guard
// What this block does
// - drive exactly one coil, chosen by polarity
// - blocked rotor switches both coils off
// - restart attempt follows shutdown automatically
// - shutdown and retry repeat while blocked
// - retry keeps drive on 0.4 s
// - shutdown keeps coils off 2.4-3.6 s
// - rotor-state output low rotating, high locked
// - resumed rotation returns to normal commutation
`ifndef FCLG_MAP_SVH
`define FCLG_MAP_SVH

`define FCLG_CLK_HZ 50000000
`define FCLG_CYC_PER_MS (`FCLG_CLK_HZ / 1000)

// retry drive-on time, typical
`define FCLG_RETRY_ON_MS 400
// shutdown time: 2400 min, 3000 typ, 3600 max
`define FCLG_SHUTDOWN_MIN_MS 2400
`define FCLG_SHUTDOWN_MS 3000
`define FCLG_SHUTDOWN_MAX_MS 3600

`define FCLG_RETRY_ON_CYC (`FCLG_RETRY_ON_MS * `FCLG_CYC_PER_MS)
`define FCLG_SHUTDOWN_CYC (`FCLG_SHUTDOWN_MS * `FCLG_CYC_PER_MS)

// timer width covers 3.6 s at 50 MHz
`define FCLG_TMR_W 28

// reset values
`define FCLG_HALL_RST 1'b0
`define FCLG_COIL_ONE_RST 1'b0
`define FCLG_COIL_TWO_RST 1'b1
`define FCLG_LOCKED_RST 1'b0

`endif

//--- logic/fclg_pkg.sv
// types shared by the fan commutation and rotor-lock guard
package fclg_pkg;

  // gray codes along run -> shut -> retry
  typedef enum logic [1:0] {
    fclg_st_run = 2'b00,
    fclg_st_shut = 2'b01,
    fclg_st_retry = 2'b11
  } fclg_state_t;

endpackage : fclg_pkg

//--- logic/fclg_timer.sv
// interval timer: counts up from a clear and flags the last cycle
`timescale 1ns/100ps
`include "fclg_map.svh"

module fclg_timer (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clear,
  input wire logic [`FCLG_TMR_W-1:0] limit,
  output logic [`FCLG_TMR_W-1:0] count,
  output logic done
);

  logic [`FCLG_TMR_W-1:0] cnt_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else if (clear || done) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + `FCLG_TMR_W'(1);
    end
  end

  // last cycle of the interval; kept free of clear so that the owner
  // may derive its clear from done without a combinational loop
  assign done = (cnt_q == limit - `FCLG_TMR_W'(1));
  assign count = cnt_q;

endmodule : fclg_timer

//--- verification/fclg_fan_model.sv
// fan motor and speed monitor model facing the lock guard
`timescale 1ns/100ps
module fclg_fan_model #(
  parameter int HALF_REV = 8
) (
  input wire logic clk_sys,
  input wire logic coil_phase_one,
  input wire logic coil_phase_two,
  input wire logic rotor_state_oe,
  input wire logic blocked,
  output logic hall_pol,
  output logic rotor_state
);
  int steps;
  initial begin
    hall_pol = 1'b0;
    steps = 0;
  end
  // rotor turns only while exactly one coil pulls and nothing blocks it
  always @(negedge clk_sys) begin
    if (!blocked && (coil_phase_one ^ coil_phase_two)) begin
      steps = steps + 1;
      if (steps >= HALF_REV) begin
        steps = 0;
        hall_pol <= ~hall_pol;
      end
    end
  end
  // pin has a pull-up, so a released pin reads high
  assign rotor_state = rotor_state_oe ? 1'b0 : 1'b1;
endmodule : fclg_fan_model

//--- verification/fclg_top_bench.sv
// self-checking bench for the commutation and rotor-lock guard
`timescale 1ns/100ps
module fclg_top_bench;
  localparam int RON = 20;
  localparam int SHUT = 60;
  logic clk_sys, resetn, blocked, hall_pol, last_hall;
  logic coil_phase_one, coil_phase_two, rotor_locked, rotor_state_oe;
  logic lock_timer_state, rotor_state;
  int mismatches, tests_run, n, quiet;
  fclg_top #(.RETRY_ON_CYC(RON), .SHUTDOWN_CYC(SHUT)) u_fclg_top (
    .clk_sys(clk_sys), .resetn(resetn), .hall_pol(hall_pol),
    .coil_phase_one(coil_phase_one), .coil_phase_two(coil_phase_two),
    .rotor_locked(rotor_locked), .rotor_state_oe(rotor_state_oe),
    .lock_timer_state(lock_timer_state));
  fclg_fan_model u_fclg_fan_model (
    .clk_sys(clk_sys), .coil_phase_one(coil_phase_one),
    .coil_phase_two(coil_phase_two), .rotor_state_oe(rotor_state_oe),
    .blocked(blocked), .hall_pol(hall_pol), .rotor_state(rotor_state));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // edges since the last polarity change, for settled coil checks
  always @(posedge clk_sys) begin
    quiet <= (hall_pol != last_hall) ? 0 : quiet + 1;
    last_hall <= hall_pol;
  end
  task automatic chk(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : chk
  task automatic chk_rng(input string what, input int lo, input int hi,
                         input int got);
    tests_run++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi,
               got);
    end
  endtask : chk_rng
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  // free rotor: one coil on, chosen by polarity, pin pulled low
  task automatic run_spin;
    repeat (50) begin
      @(negedge clk_sys);
      if (quiet >= 2) begin
        chk("coil one", hall_pol, coil_phase_one);
        chk("coil two", ~hall_pol, coil_phase_two);
      end
      chk("rotor pin", 1'b0, rotor_state);
    end
  endtask : run_spin
  // stalled rotor: shutdown, retry, shutdown again
  task automatic run_lock;
    // non-blocking so the model sees the change only at its next edge
    blocked <= 1'b1;
    n = 0;
    while (!rotor_locked && n < RON + 20) begin
      @(negedge clk_sys);
      n++;
    end
    // lock time counts from the last polarity edge, not from the block
    chk_rng("lock entry", RON - 1, RON + 1, quiet);
    chk("coils off", 1'b0, coil_phase_one | coil_phase_two);
    chk("rotor pin", 1'b1, rotor_state);
    chk("lock active", 1'b1, lock_timer_state);
    n = 0;
    while (!(coil_phase_one | coil_phase_two) && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk_rng("shutdown time", SHUT * 4 / 5, SHUT * 6 / 5, n);
    chk("one coil", 1'b1, coil_phase_one ^ coil_phase_two);
    chk("rotor pin", 1'b1, rotor_state);
    n = 0;
    while ((coil_phase_one | coil_phase_two) && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk_rng("retry time", RON - 1, RON + 1, n);
    chk("still locked", 1'b1, rotor_locked);
  endtask : run_lock
  // unblock during shutdown: retry sees rotation and leaves protection
  task automatic run_recover;
    blocked <= 1'b0;
    n = 0;
    while (rotor_locked && n < SHUT + 40) begin
      @(negedge clk_sys);
      n++;
    end
    chk("lock left", 1'b0, rotor_locked);
    chk("rotor pin", 1'b0, rotor_state);
    chk("lock active", 1'b0, lock_timer_state);
  endtask : run_recover
  initial begin
    mismatches = 0;
    tests_run = 0;
    quiet = 0;
    last_hall = 1'b0;
    blocked = 1'b0;
    resetn = 1'b0;
    repeat (3) @(negedge clk_sys);
    resetn = 1'b1;
    run_spin();
    run_lock();
    run_recover();
    run_spin();
    wrap_up();
  end
  initial begin
    repeat (3000) @(negedge clk_sys);
    mismatches++;
    wrap_up();
  end
endmodule : fclg_top_bench
